// file: src/scpc_pkg.sv
package scpc_pkg;
  // Byte offsets of the register port
  localparam logic [11:0] OFS_RIS = 12'h050;
  localparam logic [11:0] OFS_RESET_CAUSE = 12'h05c;
  localparam logic [11:0] OFS_RCC = 12'h060;
  localparam logic [11:0] OFS_XLATE = 12'h064;
  localparam logic [11:0] OFS_RUN_CLOCK_CONFIG_EXT = 12'h070;
  localparam logic [11:0] OFS_MAIN_OSC_CONTROL = 12'h07c;
  localparam logic [11:0] OFS_RGATE = 12'h100;
  localparam logic [11:0] OFS_SGATE = 12'h110;
  localparam logic [11:0] OFS_DGATE = 12'h120;
  localparam logic [11:0] OFS_DSCFG = 12'h144;
  // Field positions, basic run configuration
  localparam int RCC_BYPASS = 0;
  localparam int RCC_PD = 1;
  localparam int RCC_DIVUSE = 2;
  localparam int RCC_AUTOGATE = 3;
  localparam int RCC_SRC = 4;
  localparam int RCC_DIV = 8;
  localparam int RCC_CRYSTAL_SELECT = 16;
  // Field positions, extended run configuration
  localparam int RUN_CLOCK_CONFIG_EXT_SRC = 4;
  localparam int RUN_CLOCK_CONFIG_EXT_BYPASS = 11;
  localparam int RUN_CLOCK_CONFIG_EXT_PD = 13;
  localparam int RUN_CLOCK_CONFIG_EXT_USBPD = 14;
  localparam int RUN_CLOCK_CONFIG_EXT_DIV = 23;
  localparam int RUN_CLOCK_CONFIG_EXT_USE = 31;
  // Other fields
  localparam int RIS_MAIN_LOCK = 6;
  localparam int RIS_USB_LOCK = 7;
  localparam int RESET_CAUSE_OSCFAIL = 16;
  localparam int PRIMARY_CRYSTAL_OSC_CHECK = 0;
  localparam int DS_SRC = 4;
  localparam int DS_DIV = 23;
  // Reset values
  localparam logic [31:0] RCC_RST = 32'h000b_0f03;
  localparam logic [31:0] RUN_CLOCK_CONFIG_EXT_RST = 32'h0780_6800;
  localparam logic [31:0] DSCFG_RST = 32'h0780_0000;
  localparam logic [31:0] RGATE0_RST = 32'h0000_0040;
  // Source codes and timing
  localparam logic [2:0] SRC_MAIN = 3'h0;
  localparam logic [2:0] SRC_INTERNAL_OSCILLATOR = 3'h1;
  localparam logic [2:0] SRC_RTC = 3'h7;
  localparam logic [13:0] LOCK_SHORT = 14'h1200;
  localparam logic [13:0] LOCK_LONG = 14'h2400;
  localparam logic [4:0] CRYSTAL_SELECT_LONG_ABOVE = 5'h0f;
  localparam logic [5:0] POR_INTERNAL_OSCILLATOR_TICKS = 6'h20;
  localparam int PLL_VCO_MHZ = 400;
  localparam logic [7:0] PLL_PREDIV = 8'h02;

  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP,
                            MODE_RESTORE} scpc_mode_e;
  typedef enum logic [1:0] {FAIL_OK, FAIL_SWITCH, FAIL_POR,
                            FAIL_DONE} scpc_fail_e;
  // System clock selection handed to the clock tree
  typedef struct packed {
    logic use_pll;
    logic pll_ref_rtc;
    logic [2:0] src;
    logic [7:0] divisor;
  } scpc_clk_s;
endpackage

// file: src/scpc_top.sv
`timescale 1ns/1ps
// Contract
// - New crystal value retranslates PLL settings and relocks; same value does not
// - Both PLLs start powered down; clearing their power-down enables them
// - PLL runs 400 MHz, halved before the system divisor
// - Extended source code 7 makes the RTC oscillator the PLL reference
// - USB PLL uses main oscillator only; enabled by clearing its power-down
// - Normal PLL drives output; powered-down PLL drives nothing
// - Power-down to normal relocks; relocking PLL is never a clock source
// - Lock down-counter on main oscillator, loads 0x1200 or 0x2400 above 0x0f
// - PLL selected with enable stays on oscillator until lock count ends
// - Main lock raw flag readable in raw status; lock event raised
// - Enabled check seeing bad oscillator first sets failure flag in reset cause
// - Then internal oscillator enabled and system clock switched to it
// - Then internal reset for 32 internal periods, release, NMI request
// - Run mode clocks peripherals enabled in run gating registers
// - Deep sleep uses main oscillator or configured internal one, main powered down
// - PLL running at deep entry is powered down; deep divider override applies
// - Deep exit restores source and frequency before re-enabling clocks
// - WFI enters sleep, deep with deep enable; interrupt returns to run
// - Extended select makes extended fields override basic fields
// - Divisor equals system divider field plus one
module scpc_top #(
  parameter logic [13:0] LOCK_SHORT = scpc_pkg::LOCK_SHORT,
  parameter logic [13:0] LOCK_LONG = scpc_pkg::LOCK_LONG
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic main_osc_pin,
  input wire logic internal_oscillator_pin,
  input wire logic osc_bad_pin,
  input wire logic wfi,
  input wire logic deepsleep_en,
  input wire logic wake_irq,
  output scpc_pkg::scpc_clk_s sys_clk,
  output logic main_pll_pd,
  output logic usb_pll_pd,
  output logic main_osc_pd,
  output logic internal_oscillator_en,
  output logic cpu_clk_en,
  output logic [95:0] periph_clk_en,
  output logic main_lock_event,
  output logic usb_lock_event,
  output logic int_por,
  output logic nmi_req
);
  logic [31:0] run_clock_config, run_clock_config_ext, deepsleep_clock_config;
  logic [31:0] run_gate_regs [3];
  logic [31:0] sleep_gate_regs [3];
  logic [31:0] deepsleep_gate_regs [3];
  logic [4:0] pll_translation;
  logic osc_check_enable, osc_fail_flag;
  logic [2:0] sy1, sy2, sy3;
  logic primary_crystal_osc_tick, internal_oscillator_tick, osc_bad;
  logic ext, bypass, pd_cfg, pd_eff, pd_q, usb_pd_q, ds_pll_off;
  logic [2:0] src_eff;
  logic [5:0] div_eff;
  logic [13:0] main_cnt, usb_cnt;
  logic main_lock, usb_lock, main_lock_q, usb_lock_q;
  logic relock_main, relock_usb, restored;
  logic [5:0] por_cnt;
  logic [4:0] next_crystal_select;
  scpc_pkg::scpc_mode_e mode;
  scpc_pkg::scpc_fail_e fail_st;

  // Lock wait depends on crystal range
  function automatic logic [13:0] lock_load(input logic [4:0] x);
    return (x > scpc_pkg::CRYSTAL_SELECT_LONG_ABOVE) ? LOCK_LONG : LOCK_SHORT;
  endfunction

  function automatic logic [1:0] gate_idx(input logic [11:0] a,
                                          input logic [11:0] base);
    return a[3:2] - base[3:2];
  endfunction

  function automatic logic gate_hit(input logic [11:0] a,
                                    input logic [11:0] base);
    return (a[11:4] == base[11:4]) && (a[3:2] != 2'h3) && (a[1:0] == 2'h0);
  endfunction

  // Pin inputs cross two flops; third stage feeds edge detect only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sy1 <= 3'h0;
      sy2 <= 3'h0;
      sy3 <= 3'h0;
    end else begin
      sy1 <= {osc_bad_pin, internal_oscillator_pin, main_osc_pin};
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end
  assign primary_crystal_osc_tick = sy2[0] & ~sy3[0];
  assign internal_oscillator_tick = sy2[1] & ~sy3[1];
  assign osc_bad = sy2[2];

  // Extended fields win when selected
  always_comb begin
    ext = run_clock_config_ext[scpc_pkg::RUN_CLOCK_CONFIG_EXT_USE];
    if (ext) begin
      bypass = run_clock_config_ext[scpc_pkg::RUN_CLOCK_CONFIG_EXT_BYPASS];
      pd_cfg = run_clock_config_ext[scpc_pkg::RUN_CLOCK_CONFIG_EXT_PD];
      src_eff = run_clock_config_ext[scpc_pkg::RUN_CLOCK_CONFIG_EXT_SRC +: 3];
      div_eff = run_clock_config_ext[scpc_pkg::RUN_CLOCK_CONFIG_EXT_DIV +: 6];
    end else begin
      bypass = run_clock_config[scpc_pkg::RCC_BYPASS];
      pd_cfg = run_clock_config[scpc_pkg::RCC_PD];
      src_eff = {1'b0, run_clock_config[scpc_pkg::RCC_SRC +: 2]};
      div_eff = {2'h0, run_clock_config[scpc_pkg::RCC_DIV +: 4]};
    end
  end
  assign pd_eff = pd_cfg | ds_pll_off;
  assign next_crystal_select = wdata[scpc_pkg::RCC_CRYSTAL_SELECT +: 5];

  // Register writes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_clock_config <= scpc_pkg::RCC_RST;
      run_clock_config_ext <= scpc_pkg::RUN_CLOCK_CONFIG_EXT_RST;
      deepsleep_clock_config <= scpc_pkg::DSCFG_RST;
      osc_check_enable <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        run_gate_regs[i] <= (i == 0) ? scpc_pkg::RGATE0_RST : 32'h0;
        sleep_gate_regs[i] <= (i == 0) ? scpc_pkg::RGATE0_RST : 32'h0;
        deepsleep_gate_regs[i] <= (i == 0) ? scpc_pkg::RGATE0_RST : 32'h0;
      end
    end else if (wr) begin
      if (addr == scpc_pkg::OFS_RCC)
        run_clock_config <= wdata;
      if (addr == scpc_pkg::OFS_RUN_CLOCK_CONFIG_EXT)
        run_clock_config_ext <= wdata;
      if (addr == scpc_pkg::OFS_DSCFG)
        deepsleep_clock_config <= wdata;
      if (addr == scpc_pkg::OFS_MAIN_OSC_CONTROL)
        osc_check_enable <= wdata[scpc_pkg::PRIMARY_CRYSTAL_OSC_CHECK];
      if (gate_hit(addr, scpc_pkg::OFS_RGATE))
        run_gate_regs[gate_idx(addr, scpc_pkg::OFS_RGATE)] <= wdata;
      if (gate_hit(addr, scpc_pkg::OFS_SGATE))
        sleep_gate_regs[gate_idx(addr, scpc_pkg::OFS_SGATE)] <= wdata;
      if (gate_hit(addr, scpc_pkg::OFS_DGATE))
        deepsleep_gate_regs[gate_idx(addr, scpc_pkg::OFS_DGATE)] <= wdata;
    end
  end

  // Relock triggers: changed crystal value or leaving power-down
  assign relock_main = (wr && addr == scpc_pkg::OFS_RCC &&
    next_crystal_select != pll_translation) || (pd_q && !pd_eff);
  assign relock_usb = (wr && addr == scpc_pkg::OFS_RCC &&
    next_crystal_select != pll_translation) || (usb_pd_q && !usb_pll_pd);

  // Translated PLL setting follows the crystal value
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      pll_translation <= scpc_pkg::RCC_RST[scpc_pkg::RCC_CRYSTAL_SELECT +: 5];
    else if (wr && addr == scpc_pkg::OFS_RCC)
      pll_translation <= next_crystal_select;
  end

  // Lock counters tick on main oscillator edges only
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      main_cnt <= 14'h0;
      pd_q <= 1'b1;
    end else begin
      pd_q <= pd_eff;
      if (relock_main)
        main_cnt <= lock_load(next_crystal_select_sel());
      else if (primary_crystal_osc_tick && main_cnt != 14'h0 && !pd_eff)
        main_cnt <= main_cnt - 14'h1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      usb_cnt <= 14'h0;
      usb_pd_q <= 1'b1;
    end else begin
      usb_pd_q <= usb_pll_pd;
      if (relock_usb)
        usb_cnt <= lock_load(next_crystal_select_sel());
      else if (primary_crystal_osc_tick && usb_cnt != 14'h0 && !usb_pll_pd)
        usb_cnt <= usb_cnt - 14'h1;
    end
  end

  // Crystal value that the new count must match
  function automatic logic [4:0] next_crystal_select_sel();
    return (wr && addr == scpc_pkg::OFS_RCC) ? next_crystal_select : pll_translation;
  endfunction

  assign main_lock = !pd_q && main_cnt == 14'h0;
  assign usb_lock = !usb_pd_q && usb_cnt == 14'h0;

  // Lock events for the interrupt controller
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      main_lock_q <= 1'b0;
      usb_lock_q <= 1'b0;
    end else begin
      main_lock_q <= main_lock;
      usb_lock_q <= usb_lock;
    end
  end
  assign main_lock_event = main_lock & ~main_lock_q;
  assign usb_lock_event = usb_lock & ~usb_lock_q;

  // Power mode sequencing
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      mode <= scpc_pkg::MODE_RUN;
    else
      unique case (mode)
        scpc_pkg::MODE_RUN: begin
          if (wfi)
            mode <= deepsleep_en ? scpc_pkg::MODE_DEEP : scpc_pkg::MODE_SLEEP;
        end
        scpc_pkg::MODE_SLEEP: begin
          if (wake_irq)
            mode <= scpc_pkg::MODE_RUN;
        end
        scpc_pkg::MODE_DEEP: begin
          if (wake_irq)
            mode <= scpc_pkg::MODE_RESTORE;
        end
        scpc_pkg::MODE_RESTORE: begin
          if (restored)
            mode <= scpc_pkg::MODE_RUN;
        end
      endcase
  end

  // Clocks come back only once the entry source is usable again
  assign restored = bypass || pd_cfg || main_lock;

  // PLL forced off for the deep-sleep stay if it was running
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      ds_pll_off <= 1'b0;
    else if (mode == scpc_pkg::MODE_RUN && wfi && deepsleep_en)
      ds_pll_off <= !pd_cfg;
    else if (mode == scpc_pkg::MODE_DEEP && wake_irq)
      ds_pll_off <= 1'b0;
  end

  // Oscillator failure sequence; fallback holds until full reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fail_st <= scpc_pkg::FAIL_OK;
      por_cnt <= 6'h0;
    end else
      unique case (fail_st)
        scpc_pkg::FAIL_OK: begin
          if (osc_check_enable && osc_bad)
            fail_st <= scpc_pkg::FAIL_SWITCH;
        end
        scpc_pkg::FAIL_SWITCH: begin
          fail_st <= scpc_pkg::FAIL_POR;
          por_cnt <= scpc_pkg::POR_INTERNAL_OSCILLATOR_TICKS;
        end
        scpc_pkg::FAIL_POR: begin
          if (internal_oscillator_tick) begin
            por_cnt <= por_cnt - 6'h1;
            if (por_cnt == 6'h1)
              fail_st <= scpc_pkg::FAIL_DONE;
          end
        end
        scpc_pkg::FAIL_DONE: fail_st <= scpc_pkg::FAIL_DONE;
      endcase
  end

  // Failure flag: hardware set beats a software clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      osc_fail_flag <= 1'b0;
    else if (fail_st == scpc_pkg::FAIL_OK && osc_check_enable && osc_bad)
      osc_fail_flag <= 1'b1;
    else if (wr && addr == scpc_pkg::OFS_RESET_CAUSE)
      osc_fail_flag <= wdata[scpc_pkg::RESET_CAUSE_OSCFAIL];
  end

  // One-cycle NMI request as the internal reset lifts
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      nmi_req <= 1'b0;
    else
      nmi_req <= fail_st == scpc_pkg::FAIL_POR && internal_oscillator_tick &&
        por_cnt == 6'h1;
  end
  assign int_por = fail_st == scpc_pkg::FAIL_POR;

  // System clock selection
  always_comb begin
    sys_clk.pll_ref_rtc = ext && src_eff == scpc_pkg::SRC_RTC;
    sys_clk.use_pll = !bypass && !pd_eff && main_lock &&
      fail_st == scpc_pkg::FAIL_OK;
    sys_clk.src = src_eff;
    if (fail_st != scpc_pkg::FAIL_OK && fail_st != scpc_pkg::FAIL_SWITCH)
      sys_clk.src = scpc_pkg::SRC_INTERNAL_OSCILLATOR;
    else if (mode == scpc_pkg::MODE_DEEP)
      sys_clk.src = deepsleep_clock_config[scpc_pkg::DS_SRC +: 3];
    if (mode == scpc_pkg::MODE_DEEP && ds_pll_off)
      sys_clk.divisor = {2'h0,
        deepsleep_clock_config[scpc_pkg::DS_DIV +: 6]} + 8'h1;
    else if (run_clock_config[scpc_pkg::RCC_DIVUSE] || sys_clk.use_pll)
      sys_clk.divisor = {2'h0, div_eff} + 8'h1;
    else
      sys_clk.divisor = 8'h1;
    if (sys_clk.use_pll)
      sys_clk.divisor = {sys_clk.divisor[6:0], 1'b0};
  end

  // Oscillator and PLL power
  assign main_pll_pd = pd_eff;
  assign usb_pll_pd = run_clock_config_ext[scpc_pkg::RUN_CLOCK_CONFIG_EXT_USBPD];
  assign main_osc_pd = mode == scpc_pkg::MODE_DEEP && fail_st ==
    scpc_pkg::FAIL_OK &&
    deepsleep_clock_config[scpc_pkg::DS_SRC +: 3] != scpc_pkg::SRC_MAIN;
  assign internal_oscillator_en = fail_st != scpc_pkg::FAIL_OK || main_osc_pd ||
    src_eff == scpc_pkg::SRC_INTERNAL_OSCILLATOR;

  // Gating per mode; restore stage keeps deep gating
  always_comb begin
    logic autog;
    autog = run_clock_config[scpc_pkg::RCC_AUTOGATE];
    cpu_clk_en = mode == scpc_pkg::MODE_RUN;
    periph_clk_en = {run_gate_regs[2], run_gate_regs[1], run_gate_regs[0]};
    if (autog && mode == scpc_pkg::MODE_SLEEP)
      periph_clk_en = {sleep_gate_regs[2], sleep_gate_regs[1],
        sleep_gate_regs[0]};
    else if (autog && mode != scpc_pkg::MODE_RUN &&
      mode != scpc_pkg::MODE_SLEEP)
      periph_clk_en = {deepsleep_gate_regs[2], deepsleep_gate_regs[1],
        deepsleep_gate_regs[0]};
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      rdata <= 32'h0;
    else if (rd) begin
      rdata <= 32'h0;
      if (addr == scpc_pkg::OFS_RIS)
        rdata <= 32'(main_lock) << scpc_pkg::RIS_MAIN_LOCK |
          32'(usb_lock) << scpc_pkg::RIS_USB_LOCK;
      if (addr == scpc_pkg::OFS_RESET_CAUSE)
        rdata <= 32'(osc_fail_flag) << scpc_pkg::RESET_CAUSE_OSCFAIL;
      if (addr == scpc_pkg::OFS_RCC)
        rdata <= run_clock_config;
      if (addr == scpc_pkg::OFS_XLATE)
        rdata <= 32'(pll_translation);
      if (addr == scpc_pkg::OFS_RUN_CLOCK_CONFIG_EXT)
        rdata <= run_clock_config_ext;
      if (addr == scpc_pkg::OFS_MAIN_OSC_CONTROL)
        rdata <= 32'(osc_check_enable);
      if (addr == scpc_pkg::OFS_DSCFG)
        rdata <= deepsleep_clock_config;
      if (gate_hit(addr, scpc_pkg::OFS_RGATE))
        rdata <= run_gate_regs[gate_idx(addr, scpc_pkg::OFS_RGATE)];
      if (gate_hit(addr, scpc_pkg::OFS_SGATE))
        rdata <= sleep_gate_regs[gate_idx(addr, scpc_pkg::OFS_SGATE)];
      if (gate_hit(addr, scpc_pkg::OFS_DGATE))
        rdata <= deepsleep_gate_regs[gate_idx(addr, scpc_pkg::OFS_DGATE)];
    end
  end

  // Helper for the reset length check
  logic [5:0] h_ticks;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      h_ticks <= 6'h0;
    else if (!int_por)
      h_ticks <= 6'h0;
    else if (internal_oscillator_tick)
      h_ticks <= h_ticks + 6'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_relock_clears: assert property (relock_main |=> !main_lock)
    else $error("lock flag set right after relock");
  a_same_crystal_select: assert property (wr && addr == scpc_pkg::OFS_RCC &&
    next_crystal_select == pll_translation && !(pd_q && !pd_eff) |-> !relock_main)
    else $error("same crystal value relocked");
  a_load_value: assert property (relock_main |=>
    main_cnt == lock_load(pll_translation) || pd_eff)
    else $error("lock counter load wrong");
  a_pll_locked: assert property (sys_clk.use_pll |-> main_lock && !main_pll_pd)
    else $error("PLL used before lock");
  a_fail_order: assert property (fail_st == scpc_pkg::FAIL_OK &&
    osc_check_enable && osc_bad |=> osc_fail_flag && internal_oscillator_en ##1
    sys_clk.src == scpc_pkg::SRC_INTERNAL_OSCILLATOR && int_por)
    else $error("failure sequence order wrong");
  a_por_len: assert property ($fell(int_por) |-> h_ticks == 6'h20 && nmi_req)
    else $error("internal reset length wrong");
  a_cpu_gate: assert property (mode != scpc_pkg::MODE_RUN |-> !cpu_clk_en)
    else $error("cpu clocked outside run");
  a_deep_pll_off: assert property (mode == scpc_pkg::MODE_RUN && wfi &&
    deepsleep_en |=> main_pll_pd)
    else $error("PLL left on in deep sleep");
  a_deep_gate: assert property (mode == scpc_pkg::MODE_DEEP &&
    run_clock_config[scpc_pkg::RCC_AUTOGATE] |-> periph_clk_en[31:0] ==
    deepsleep_gate_regs[0]) else $error("deep gating wrong");

  c_lock: cover property (relock_main ##[1:1000] main_lock_event);
  c_deep_trip: cover property (mode == scpc_pkg::MODE_DEEP ##1
    mode == scpc_pkg::MODE_RESTORE ##[1:1000] mode == scpc_pkg::MODE_RUN);
  c_fail: cover property ($fell(int_por));
endmodule // scpc_top

// file: verif/scpc_osc_model.sv
`timescale 1ns/1ps
// Main crystal, internal oscillator and band monitor at the far side
module scpc_osc_model (
  input wire logic main_osc_pd,
  input wire logic internal_oscillator_en,
  input wire logic bad_req,
  output logic main_osc_pin,
  output logic internal_oscillator_pin,
  output logic osc_bad_pin
);
  // Periods 100 ns and 150 ns, off the rising system clock edges
  // A stopped oscillator rests low rather than freezing mid-cycle
  initial begin
    main_osc_pin = 1'b0;
    forever #50 main_osc_pin = main_osc_pd ? 1'b0 : ~main_osc_pin;
  end
  initial begin
    internal_oscillator_pin = 1'b0;
    forever #75 internal_oscillator_pin = internal_oscillator_en ? ~internal_oscillator_pin : 1'b0;
  end
  // Out-of-band level only when the bench asks for a failure
  assign osc_bad_pin = bad_req;
endmodule // scpc_osc_model

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wfi = 1'b0;
  logic deepsleep_en = 1'b0;
  logic wake_irq = 1'b0;
  logic bad_req = 1'b0;
  logic [31:0] rdata, rv;
  logic main_osc_pin, internal_oscillator_pin, osc_bad_pin, main_pll_pd, usb_pll_pd;
  logic main_osc_pd, internal_oscillator_en, cpu_clk_en, main_lock_event, usb_lock_event;
  logic int_por, nmi_req;
  logic [95:0] periph_clk_en;
  scpc_pkg::scpc_clk_s sys_clk, saved;
  int num_errors = 0;
  int comparisons = 0;
  int n;

  // Short lock counts keep the run brief
  scpc_top #(.LOCK_SHORT(14'h10), .LOCK_LONG(14'h20)) scpc_top_i (
    .clock, .nrst, .addr, .wdata, .wr, .rd, .rdata, .main_osc_pin,
    .internal_oscillator_pin, .osc_bad_pin, .wfi, .deepsleep_en, .wake_irq, .sys_clk,
    .main_pll_pd, .usb_pll_pd, .main_osc_pd, .internal_oscillator_en, .cpu_clk_en,
    .periph_clk_en, .main_lock_event, .usb_lock_event, .int_por, .nmi_req);
  scpc_osc_model scpc_osc_model_i (.main_osc_pd, .internal_oscillator_en, .bad_req,
    .main_osc_pin, .internal_oscillator_pin, .osc_bad_pin);

  // 40 MHz system clock
  always #12.5 clock = ~clock;

  // Closing report, also reached from an expired wait
  task automatic give_verdict();
    $display("Counts: %0d compared, %0d bad", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Case equality so an unknown never matches
  task automatic chk(input string what, input logic [95:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic bound(input int cnt, input int lim);
    if (cnt >= lim) begin
      num_errors++;
      $display("MISMATCH wait expected event seen timeout");
      give_verdict();
    end
  endtask
  // Step past an edge so its updates have landed
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  // Read data land in the cycle after the strobe and hold until the next read
  task automatic rd_reg(input logic [11:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask
  task automatic strobe(input logic s_wfi, s_deep, s_wake);
    @(posedge clock);
    wfi <= s_wfi;
    deepsleep_en <= s_deep;
    wake_irq <= s_wake;
    @(posedge clock);
    wfi <= 1'b0;
    wake_irq <= 1'b0;
    #1;
  endtask
  task automatic wait_run(input int lim);
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
    bound(n, lim);
  endtask

  // Reset values and an unmapped word
  task automatic t_reset();
    chk("main_pll_pd", main_pll_pd, 1'b1);
    chk("usb_pll_pd", usb_pll_pd, 1'b1);
    rd_reg(scpc_pkg::OFS_RCC);
    chk("rcc", rv, scpc_pkg::RCC_RST);
    rd_reg(scpc_pkg::OFS_RUN_CLOCK_CONFIG_EXT);
    chk("run_clock_config_ext", rv, scpc_pkg::RUN_CLOCK_CONFIG_EXT_RST);
    rd_reg(scpc_pkg::OFS_RGATE);
    chk("rgate0", rv, scpc_pkg::RGATE0_RST);
    rd_reg(12'h10c);
    chk("unmapped", rv, 32'h0);
    $display("Test reset done");
  endtask
  // Enable and select the PLL in one write
  task automatic t_onestep();
    wr_reg(scpc_pkg::OFS_RCC, 32'h000b_0304);
    chk("main_pll_pd", main_pll_pd, 1'b0);
    n = 0;
    while (main_lock_event !== 1'b1 && n < 400) begin
      chk("use_pll", sys_clk.use_pll, 1'b0);
      tick();
      n++;
    end
    bound(n, 400);
    chk("short lock", n inside {[56:80]}, 1'b1);
    tick();
    chk("use_pll", sys_clk.use_pll, 1'b1);
    chk("divisor", sys_clk.divisor, 8'h08);
    rd_reg(scpc_pkg::OFS_RIS);
    chk("lock", rv[scpc_pkg::RIS_MAIN_LOCK], 1'b1);
    $display("Test one-step done");
  endtask
  // Careful change to a crystal above 0x0f
  task automatic t_relock();
    wr_reg(scpc_pkg::OFS_RCC, 32'h000b_0301);
    rd_reg(scpc_pkg::OFS_RIS);
    chk("same crystal_select", rv[scpc_pkg::RIS_MAIN_LOCK], 1'b1);
    wr_reg(scpc_pkg::OFS_RCC, 32'h0010_0301);
    rd_reg(scpc_pkg::OFS_RIS);
    chk("new crystal_select", rv[scpc_pkg::RIS_MAIN_LOCK], 1'b0);
    wr_reg(scpc_pkg::OFS_RCC, 32'h0010_0305);
    n = 4;
    while (main_lock_event !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    bound(n, 400);
    chk("long lock", n inside {[120:150]}, 1'b1);
    wr_reg(scpc_pkg::OFS_RCC, 32'h0010_0304);
    chk("use_pll", sys_clk.use_pll, 1'b1);
    $display("Test relock done");
  endtask
  // Gating in run, sleep and deep sleep, and the deep-sleep clock
  task automatic t_sleep();
    wr_reg(scpc_pkg::OFS_RGATE, 32'h11);
    wr_reg(scpc_pkg::OFS_RGATE + 12'h004, 32'h55);
    wr_reg(scpc_pkg::OFS_SGATE, 32'h22);
    wr_reg(scpc_pkg::OFS_DGATE, 32'h44);
    wr_reg(scpc_pkg::OFS_DSCFG, 32'h0280_0010);
    wr_reg(scpc_pkg::OFS_RCC, 32'h0010_030c);
    chk("run gates", periph_clk_en[63:0], 64'h55_0000_0011);
    saved = sys_clk;
    strobe(1'b1, 1'b0, 1'b0);
    tick();
    chk("sleep cpu", cpu_clk_en, 1'b0);
    chk("sleep gates", periph_clk_en[31:0], 32'h22);
    chk("sleep clk", sys_clk, saved);
    strobe(1'b0, 1'b0, 1'b1);
    wait_run(20);
    strobe(1'b1, 1'b1, 1'b0);
    tick();
    chk("deep cpu", cpu_clk_en, 1'b0);
    chk("deep gates", periph_clk_en[31:0], 32'h44);
    chk("deep osc", {main_osc_pd, internal_oscillator_en}, 2'b11);
    chk("deep pll", main_pll_pd, 1'b1);
    chk("deep div", sys_clk.divisor, 8'h06);
    strobe(1'b0, 1'b0, 1'b1);
    wait_run(400);
    chk("restored", sys_clk, saved);
    chk("main osc", main_osc_pd, 1'b0);
    wr_reg(scpc_pkg::OFS_RCC, 32'h0010_0304);
    strobe(1'b1, 1'b0, 1'b0);
    tick();
    chk("no auto", periph_clk_en[31:0], 32'h11);
    strobe(1'b0, 1'b0, 1'b1);
    wait_run(20);
    $display("Test sleep done");
  endtask
  // Extended fields, RTC reference and USB PLL
  task automatic t_ext();
    wr_reg(scpc_pkg::OFS_RUN_CLOCK_CONFIG_EXT, 32'h8180_0870);
    chk("rtc ref", sys_clk.pll_ref_rtc, 1'b1);
    chk("ext src", sys_clk.src, scpc_pkg::SRC_RTC);
    chk("ext div", sys_clk.divisor, 8'h04);
    chk("usb pd", usb_pll_pd, 1'b0);
    n = 0;
    while (usb_lock_event !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    bound(n, 400);
    rd_reg(scpc_pkg::OFS_RIS);
    chk("usb lock", rv[scpc_pkg::RIS_USB_LOCK], 1'b1);
    $display("Test extended done");
  endtask
  // Oscillator failure, fallback and internal reset
  task automatic t_fail();
    wr_reg(scpc_pkg::OFS_MAIN_OSC_CONTROL, 32'h1);
    @(posedge clock);
    bad_req <= 1'b1;
    n = 0;
    while (int_por !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    bound(n, 20);
    chk("internal_oscillator on", internal_oscillator_en, 1'b1);
    chk("fallback", sys_clk.src, scpc_pkg::SRC_INTERNAL_OSCILLATOR);
    n = 0;
    while (int_por === 1'b1 && n < 400) begin
      tick();
      n++;
    end
    bound(n, 400);
    chk("por len", n inside {[180:200]}, 1'b1);
    chk("nmi", nmi_req, 1'b1);
    tick();
    chk("nmi end", nmi_req, 1'b0);
    bad_req <= 1'b0;
    rd_reg(scpc_pkg::OFS_RESET_CAUSE);
    chk("fail flag", rv[scpc_pkg::RESET_CAUSE_OSCFAIL], 1'b1);
    $display("Test failure done");
  endtask

  // Reset for 16 cycles, then the scenarios in order
  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    tick();
    t_reset();
    t_onestep();
    t_relock();
    t_sleep();
    t_ext();
    t_fail();
    give_verdict();
  end
endmodule // tb_top
